/* File: design/rcst_pkg.sv */
// Package: offsets, fields, codes and timing for the self-test controller
package rcst_pkg;
    // ******************************
    // Register byte offsets
    // ******************************
    localparam logic [7:0] RCST_OFF_CTRL   = 8'h00;
    localparam logic [7:0] RCST_OFF_LOOP   = 8'h04;
    localparam logic [7:0] RCST_OFF_DIAG1  = 8'h08;
    localparam logic [7:0] RCST_OFF_TRIM   = 8'h0c;
    localparam logic [7:0] RCST_OFF_STAT   = 8'h10;
    localparam logic [7:0] RCST_OFF_SWDAC  = 8'h14;
    localparam logic [7:0] RCST_OFF_SWRES  = 8'h18;

    // ******************************
    // Field positions
    // ******************************
    localparam int RCST_CTRL_EXE    = 4;
    localparam int RCST_CTRL_CLR    = 5;
    localparam int RCST_CTRL_TH_LO  = 8;
    localparam int RCST_LOOP_FGD    = 0;
    localparam int RCST_LOOP_EIE    = 1;
    localparam int RCST_LOOP_UNITY  = 2;
    localparam int RCST_LOOP_RSA    = 3;
    localparam int RCST_LOOP_RSB    = 4;
    localparam int RCST_LOOP_XOS    = 5;
    localparam int RCST_LOOP_XAS    = 6;
    localparam int RCST_LOOP_XAC_LO = 8;
    localparam int RCST_LOOP_RC_LO  = 12;
    localparam int RCST_D1_SCT_LO   = 0;
    localparam int RCST_D1_EJP_LO   = 2;
    localparam int RCST_D1_SQCLR    = 4;
    localparam int RCST_D1_ERST     = 5;
    localparam int RCST_D1_SCRUN    = 8;
    localparam int RCST_TRIM_COS_LO = 16;
    localparam int RCST_ST_BUSY     = 0;
    localparam int RCST_ST_DONE     = 1;
    localparam int RCST_ST_PASS     = 2;
    localparam int RCST_ST_ERR      = 3;
    localparam int RCST_ST_LONG     = 4;
    localparam int RCST_ST_CODE_LO  = 8;
    localparam int RCST_SW_VALID    = 16;

    // ******************************
    // Reset values
    // ******************************
    localparam logic [31:0] RCST_LOOP_RST  = 32'h0000_4249;
    localparam logic [31:0] RCST_DIAG1_RST = 32'h0000_0000;

    // ******************************
    // Test codes
    // ******************************
    localparam logic [3:0] RCST_C_NONE   = 4'h0;
    localparam logic [3:0] RCST_C_RSV1   = 4'h1;
    localparam logic [3:0] RCST_C_SQLO   = 4'h2;
    localparam logic [3:0] RCST_C_SQHI   = 4'h3;
    localparam logic [3:0] RCST_C_ADC    = 4'h4;
    localparam logic [3:0] RCST_C_ANG0   = 4'h5;
    localparam logic [3:0] RCST_C_ANG45  = 4'h6;
    localparam logic [3:0] RCST_C_ANG270 = 4'h7;
    localparam logic [3:0] RCST_C_RSV8   = 4'h8;
    localparam logic [3:0] RCST_C_SIGE   = 4'h9;
    localparam logic [3:0] RCST_C_DISC   = 4'ha;
    localparam logic [3:0] RCST_C_DISS   = 4'hb;
    localparam logic [3:0] RCST_C_CONV   = 4'hc;
    localparam logic [3:0] RCST_C_PSHT   = 4'hd;
    localparam logic [3:0] RCST_C_GSHT   = 4'he;
    localparam logic [3:0] RCST_C_RSVF   = 4'hf;

    // ******************************
    // Timing
    // ******************************
    localparam longint RCST_CLK_HZ    = 200_000_000;
    localparam longint RCST_LONG_US   = 10_000;
    localparam longint RCST_SHORT_US  = 78;
    localparam int     RCST_LONG_CYC  = int'(RCST_LONG_US * RCST_CLK_HZ / 1_000_000);
    localparam int     RCST_SHORT_CYC = int'(RCST_SHORT_US * RCST_CLK_HZ / 1_000_000);
    localparam int     RCST_ADC_STEPS = 3;
    localparam int     RCST_SWADC_CYC = 16;
endpackage

/* File: design/rcst_adc_judge.sv */
// ADC self-test judge: three references, each against a threshold
`timescale 1ns/1ps
`default_nettype none
module rcst_adc_judge (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [1:0]  i_thresh,
    input  wire logic [11:0] i_sample,
    input  wire logic        i_sample_vld,
    output logic [1:0]       o_ref_sel,
    output logic             o_done,
    output logic             o_pass
);
    import rcst_pkg::*;

    // Ideal codes of 1 V, 2.5 V, 4 V on a 5 V, 12-bit scale
    localparam logic [11:0] REF_1V  = 12'h333;
    localparam logic [11:0] REF_25V = 12'h800;
    localparam logic [11:0] REF_4V  = 12'hccc;

    logic [1:0]  step_q;
    logic        run_q;
    logic        ok_q;
    logic [11:0] ideal;
    logic [11:0] diff;
    logic [11:0] tol;
    logic        in_tol;

    assign ideal  = (step_q == 2'd0) ? REF_1V : (step_q == 2'd1) ? REF_25V : REF_4V;
    assign diff   = (i_sample > ideal) ? i_sample - ideal : ideal - i_sample;
    // Threshold setting picks a window of 8, 16, 32 or 64 LSB
    assign tol    = 12'h008 << i_thresh;
    assign in_tol = (diff <= tol);

    // [RL4] References in order
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            step_q    <= 2'd0;
            run_q     <= 1'b0;
            ok_q      <= 1'b0;
            o_done    <= 1'b0;
            o_pass    <= 1'b0;
            o_ref_sel <= 2'd0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                step_q    <= 2'd0;
                run_q     <= 1'b1;
                ok_q      <= 1'b1;
                o_ref_sel <= 2'd0;
            end else if (run_q && i_sample_vld) begin
                if (step_q == 2'(RCST_ADC_STEPS - 1)) begin
                    run_q  <= 1'b0;
                    o_done <= 1'b1;
                    o_pass <= ok_q & in_tol;
                end else begin
                    ok_q      <= ok_q & in_tol;
                    step_q    <= step_q + 2'd1;
                    o_ref_sel <= step_q + 2'd1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: design/rcst_top.sv */
// Self-test controller of the resolver converter, APB slave
//
// Contract
// [RL1] Code zero makes execute ineffective
// [RL2] Software never writes reserved codes
// [RL3] Codes 2/3 run sum-of-squares low/high
// [RL4] Code 4 runs ADC test, three references
// [RL5] Codes 5-7 run angle test 0/45/270
// [RL6] Codes 9-b signal error and disconnection
// [RL7] Codes c-e conversion, power, ground short
// [RL8] Outputs follow stimulus; error irq possible
// [RL9] Long tests power-up only, 10 ms
// [RL10] Short tests keep angle tracking
// [RL11] Long and short class membership
// [RL12] Long tests before short at power-up
// [RL13] Software enables forced gain, irq off
// [RL14] Software sets short check timing 00
// [RL15] Software polls short-check-running flag
// [RL16] Software zeroes both angle trims
// [RL17] Software sets judge period to 10
// [RL18] Software restores default gain, amplitude
// [RL19] Software clears sum-of-squares counter first
// [RL20] Clear writes reset result, error, counter
// [RL21] Software restores changed settings afterwards
// [RL22] CPU DAC code converted and returned
// [RL23] Execute with valid code starts it
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rcst_top #(
    parameter int LONG_CYC  = rcst_pkg::RCST_LONG_CYC,
    parameter int SHORT_CYC = rcst_pkg::RCST_SHORT_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_core_fail,
    input  wire logic        i_short_run,
    input  wire logic [11:0] i_adc_result,
    input  wire logic        i_adc_valid,
    output logic [3:0]       o_stim_sel,
    output logic             o_stim_on,
    output logic             o_track_hold,
    output logic [1:0]       o_adc_ref_sel,
    output logic             o_adc_conv,
    output logic [11:0]      o_adc_dac_code,
    output logic             o_forced_gain_disable,
    output logic             o_error_irq_enable,
    output logic             o_sumsq_count_clear,
    output logic             o_error_signal_reset,
    output logic [1:0]       o_short_check_timing,
    output logic [1:0]       o_error_judge_period,
    output logic [23:0]      o_angle_trim,
    output logic [11:0]      o_gain_amp_sel
);
    import rcst_pkg::*;

    typedef enum logic [1:0] {RCST_IDLE, RCST_RUN, RCST_SWCONV} rcst_state_t;

    // ************************************************
    // Code classification
    // ************************************************
    function automatic logic rcst_is_long(input logic [3:0] c);
        // [RL11] Class membership
        rcst_is_long = (c == RCST_C_ANG0) || (c == RCST_C_ANG45) ||
                       (c == RCST_C_ANG270) || (c == RCST_C_CONV);
    endfunction

    function automatic logic rcst_is_legal(input logic [3:0] c);
        // [RL1] Zero and reserved codes never start
        rcst_is_legal = (c != RCST_C_NONE) && (c != RCST_C_RSV1) &&
                        (c != RCST_C_RSV8) && (c != RCST_C_RSVF);
    endfunction

    // ************************************************
    // Registers
    // ************************************************
    rcst_state_t  state_q;
    logic [3:0]   code_q;
    logic [1:0]   thr_q;
    logic [31:0]  loop_q;
    logic [31:0]  diag_q;
    logic [23:0]  trim_q;
    logic [11:0]  dac_q;
    logic [11:0]  swres_q;
    logic         swvld_q;
    logic [3:0]   run_code_q;
    logic         busy_q;
    logic         done_q;
    logic         pass_q;
    logic         err_q;
    logic [31:0]  cnt_q;
    logic [4:0]   swcnt_q;
    logic         srun_m_q;
    logic         srun_q;
    logic         fail_m_q;
    logic         fail_q;

    // ************************************************
    // Bus decode
    // ************************************************
    wire        acc      = i_psel & i_penable;
    wire        wr       = acc & i_pwrite;
    wire        hit_ctrl = (i_paddr == RCST_OFF_CTRL);
    wire        hit_loop = (i_paddr == RCST_OFF_LOOP);
    wire        hit_d1   = (i_paddr == RCST_OFF_DIAG1);
    wire        hit_trim = (i_paddr == RCST_OFF_TRIM);
    wire        hit_stat = (i_paddr == RCST_OFF_STAT);
    wire        hit_swd  = (i_paddr == RCST_OFF_SWDAC);
    wire        hit_swr  = (i_paddr == RCST_OFF_SWRES);
    wire        mapped   = hit_ctrl | hit_loop | hit_d1 | hit_trim | hit_stat | hit_swd | hit_swr;
    wire        wr_ctrl  = wr & hit_ctrl;
    wire [3:0]  wr_code  = i_pwdata[3:0];
    // [RL23] Start on execute with permitted code
    wire        start    = wr_ctrl & i_pwdata[RCST_CTRL_EXE] & rcst_is_legal(wr_code) &
                           (state_q == RCST_IDLE);
    // [RL20] Clear requests
    wire        clr_res  = wr_ctrl & i_pwdata[RCST_CTRL_CLR];
    wire        clr_err  = wr & hit_d1 & i_pwdata[RCST_D1_ERST];
    wire        clr_sq   = wr & hit_d1 & i_pwdata[RCST_D1_SQCLR];
    wire        sw_start = wr & hit_swd & (state_q == RCST_IDLE);
    wire        is_adc   = (run_code_q == RCST_C_ADC);
    wire [31:0] run_len  = rcst_is_long(run_code_q) ? LONG_CYC : SHORT_CYC;
    wire        timed_end = (state_q == RCST_RUN) && !is_adc && (cnt_q >= run_len - 1);
    wire [1:0]  adc_ref;
    wire        adc_done;
    wire        adc_pass;
    wire        test_end = timed_end | ((state_q == RCST_RUN) && is_adc && adc_done);
    wire        end_pass = is_adc ? adc_pass : !fail_q;

    wire [31:0] ctrl_rd = {22'h0, thr_q, 4'h0, code_q};
    wire [31:0] d1_rd   = {23'h0, srun_q, 2'h0, 2'h0, diag_q[3:0]};
    wire [31:0] stat_rd = {20'h0, run_code_q, 3'h0, rcst_is_long(run_code_q),
                           err_q, pass_q, done_q, busy_q};
    wire [31:0] swr_rd  = {15'h0, swvld_q, 4'h0, swres_q};
    wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                          hit_loop ? loop_q :
                          hit_d1   ? d1_rd :
                          hit_trim ? {8'h0, trim_q} :
                          hit_stat ? stat_rd :
                          hit_swd  ? {20'h0, dac_q} :
                          hit_swr  ? swr_rd : 32'h0;

    // ************************************************
    // Synchronisers
    // ************************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            srun_m_q <= 1'b0;
            srun_q   <= 1'b0;
            fail_m_q <= 1'b0;
            fail_q   <= 1'b0;
        end else begin
            srun_m_q <= i_short_run;
            srun_q   <= srun_m_q;
            fail_m_q <= i_core_fail;
            fail_q   <= fail_m_q;
        end
    end

    // ************************************************
    // APB slave, no wait states
    // ************************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~mapped;
            o_prdata  <= (i_psel & ~i_penable & ~i_pwrite) ? rd_mux : 32'h0;
        end
    end

    // Writes land only in the access cycle with pready high
    wire wtk = wr & o_pready;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            code_q <= RCST_C_NONE;
            thr_q  <= 2'd0;
            loop_q <= RCST_LOOP_RST;
            diag_q <= RCST_DIAG1_RST;
            trim_q <= 24'h0;
            dac_q  <= 12'h0;
        end else if (wtk) begin
            if (hit_ctrl) begin
                code_q <= wr_code;
                thr_q  <= i_pwdata[RCST_CTRL_TH_LO +: 2];
            end
            if (hit_loop) begin
                loop_q <= {16'h0, i_pwdata[15:0]};
            end
            if (hit_d1) begin
                // Clear bits self-reset, not stored
                diag_q <= {28'h0, i_pwdata[3:0]};
            end
            if (hit_trim) begin
                trim_q <= i_pwdata[23:0];
            end
            if (hit_swd) begin
                dac_q <= i_pwdata[11:0];
            end
        end
    end

    // ************************************************
    // Test sequencer
    // ************************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_q    <= RCST_IDLE;
            run_code_q <= RCST_C_NONE;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            pass_q     <= 1'b0;
            err_q      <= 1'b0;
            cnt_q      <= 32'h0;
            swcnt_q    <= 5'h0;
            swres_q    <= 12'h0;
            swvld_q    <= 1'b0;
        end else begin
            case (state_q)
                RCST_IDLE: begin
                    if (start & wtk) begin
                        // [RL3] [RL5] [RL6] [RL7] Code latched selects stimulus
                        run_code_q <= wr_code;
                        busy_q     <= 1'b1;
                        done_q     <= 1'b0;
                        cnt_q      <= 32'h0;
                        state_q    <= RCST_RUN;
                    end else if (sw_start & wtk) begin
                        swvld_q <= 1'b0;
                        swcnt_q <= 5'h0;
                        state_q <= RCST_SWCONV;
                    end
                end
                RCST_RUN: begin
                    cnt_q <= cnt_q + 32'h1;
                    // [RL9] Long test bounded at 10 ms
                    if (test_end) begin
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        pass_q  <= end_pass;
                        state_q <= RCST_IDLE;
                    end
                end
                RCST_SWCONV: begin
                    swcnt_q <= swcnt_q + 5'h1;
                    // [RL22] Result of CPU code conversion
                    if (i_adc_valid && swcnt_q != 5'h0) begin
                        swres_q <= i_adc_result;
                        swvld_q <= 1'b1;
                        state_q <= RCST_IDLE;
                    end
                end
                default: state_q <= RCST_IDLE;
            endcase
            // [RL23] Result stands until cleared or a new test starts; set wins
            if (clr_res & wtk & ~test_end) begin
                done_q <= 1'b0;
                pass_q <= 1'b0;
            end
            // [RL8] Error seen during stimulus is sticky
            if (busy_q & fail_q) begin
                err_q <= 1'b1;
            end else if (clr_err & wtk) begin
                err_q <= 1'b0;
            end
        end
    end

    rcst_adc_judge rcst_adc_judge_inst (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_start      (start & wtk & (wr_code == RCST_C_ADC)),
        .i_thresh     (thr_q),
        .i_sample     (i_adc_result),
        .i_sample_vld (i_adc_valid & (state_q == RCST_RUN)),
        .o_ref_sel    (adc_ref),
        .o_done       (adc_done),
        .o_pass       (adc_pass)
    );

    // ************************************************
    // Outputs to the converter core
    // ************************************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_stim_sel            <= RCST_C_NONE;
            o_stim_on             <= 1'b0;
            o_track_hold          <= 1'b0;
            o_adc_ref_sel         <= 2'd0;
            o_adc_conv            <= 1'b0;
            o_adc_dac_code        <= 12'h0;
            o_forced_gain_disable <= 1'b0;
            o_error_irq_enable    <= 1'b0;
            o_sumsq_count_clear   <= 1'b0;
            o_error_signal_reset  <= 1'b0;
            o_short_check_timing  <= 2'd0;
            o_error_judge_period  <= 2'd0;
            o_angle_trim          <= 24'h0;
            o_gain_amp_sel        <= 12'h0;
        end else begin
            o_stim_sel <= (state_q == RCST_RUN) ? run_code_q : RCST_C_NONE;
            o_stim_on  <= (state_q == RCST_RUN) & ~test_end;
            // [RL10] Only long tests take the angle path
            o_track_hold <= (state_q == RCST_RUN) & ~test_end & rcst_is_long(run_code_q);
            // Judge reference index mirrored from sample count
            o_adc_ref_sel  <= (state_q == RCST_RUN && is_adc) ? adc_ref : 2'd0;
            o_adc_conv     <= (state_q == RCST_SWCONV) & (swcnt_q == 5'h0);
            o_adc_dac_code <= dac_q;
            o_forced_gain_disable <= loop_q[RCST_LOOP_FGD];
            o_error_irq_enable    <= loop_q[RCST_LOOP_EIE];
            // [RL20] Clear pulses to core
            o_sumsq_count_clear   <= clr_sq & wtk;
            o_error_signal_reset  <= clr_err & wtk;
            o_short_check_timing  <= diag_q[RCST_D1_SCT_LO +: 2];
            o_error_judge_period  <= diag_q[RCST_D1_EJP_LO +: 2];
            o_angle_trim          <= trim_q;
            o_gain_amp_sel        <= loop_q[11:0];
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_zero_no_start; // [RL1]
        @(posedge i_mclk) disable iff (i_rst)
        (state_q == RCST_IDLE && wtk && hit_ctrl && i_pwdata[3:0] == 4'h0)
            |=> (state_q != RCST_RUN);
    endproperty
    a_zero_no_start: assert property (p_zero_no_start) else $error("zero code started test");

    property p_start_code; // [RL23]
        @(posedge i_mclk) disable iff (i_rst)
        (start && wtk) |=> (state_q == RCST_RUN && run_code_q == $past(i_pwdata[3:0]) && busy_q);
    endproperty
    a_start_code: assert property (p_start_code) else $error("test did not start with code");

    property p_stim; // [RL3]
        @(posedge i_mclk) disable iff (i_rst)
        (state_q == RCST_RUN && !test_end) |=> (o_stim_on && o_stim_sel == $past(run_code_q));
    endproperty
    a_stim: assert property (p_stim) else $error("stimulus not driven");

    property p_track; // [RL10]
        @(posedge i_mclk) disable iff (i_rst)
        (state_q == RCST_RUN && !rcst_is_long(run_code_q)) |=> !o_track_hold;
    endproperty
    a_track: assert property (p_track) else $error("short test held tracking");

    property p_class; // [RL11]
        @(posedge i_mclk) disable iff (i_rst)
        (state_q == RCST_RUN && run_code_q == RCST_C_CONV && !test_end) |=> o_track_hold;
    endproperty
    a_class: assert property (p_class) else $error("conversion test not long");

    property p_done_hold; // [RL23]
        @(posedge i_mclk) disable iff (i_rst)
        (done_q && !(clr_res && wtk) && !(start && wtk)) |=> done_q;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("result lost before clear");

    property p_clear; // [RL20]
        @(posedge i_mclk) disable iff (i_rst)
        (clr_sq && wtk) |=> o_sumsq_count_clear ##1 !o_sumsq_count_clear;
    endproperty
    a_clear: assert property (p_clear) else $error("counter clear pulse wrong");

    property p_sw; // [RL22]
        @(posedge i_mclk) disable iff (i_rst)
        (sw_start && wtk) |=> (state_q == RCST_SWCONV) ##1 o_adc_conv;
    endproperty
    a_sw: assert property (p_sw) else $error("software conversion not launched");

    property p_err; // [RL8]
        @(posedge i_mclk) disable iff (i_rst)
        (busy_q && fail_q) |=> err_q [*2];
    endproperty
    a_err: assert property (p_err) else $error("error flag not sticky");
endmodule
`default_nettype wire

/* File: bench/rcst_front_model.sv */
// Front-end model: converter answers and core fault level
`timescale 1ns/1ps
`default_nettype none
module rcst_front_model (
    input  wire logic        i_mclk,
    input  wire logic        i_conv,
    input  wire logic [11:0] i_code,
    input  wire logic [1:0]  i_ref,
    input  wire logic        i_adc_on,
    input  wire logic        i_fail_cmd,
    input  wire logic [3:0]  i_lag,
    output logic [11:0]      o_result,
    output logic             o_valid,
    output logic             o_fail
);
    logic [4:0]  cnt = 5'h0;
    logic [11:0] val = 12'h0;
    logic        sw  = 1'b0;
    logic [11:0] refv;
    // 1 V, 2.5 V, 4 V of a 5 V span; reference taken at hand-over
    assign refv = (i_ref == 2'h0) ? 12'h333 : (i_ref == 2'h1) ? 12'h800 : 12'hccc;
    initial o_result = 12'h0;
    initial o_valid = 1'b0;
    assign o_fail = i_fail_cmd;
    always @(posedge i_mclk) begin
        o_valid <= (cnt == 5'h1);
        // No hold: inverse shown outside the pulse
        o_result <= (cnt == 5'h1) ? (sw ? val : refv) : ~val;
        if (cnt != 5'h0)
            cnt <= cnt - 5'h1;
        // ideal conversion of the DAC code
        if (i_conv) begin
            val <= i_code;
            sw  <= 1'b1;
            cnt <= {1'b0, i_lag} + 5'h2;
        end else if (i_adc_on && cnt == 5'h0) begin
            val <= refv;
            sw  <= 1'b0;
            cnt <= {1'b0, i_lag} + 5'h2;
        end
    end
endmodule
`default_nettype wire

/* File: bench/resolver_converter_self_test_tb_top.sv */
// Testbench: register access, self-test runs, DAC conversions
`timescale 1ns/1ps
`default_nettype none
module resolver_converter_self_test_tb_top;
    import rcst_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, srun = 1'b1, fcmd = 1'b0;
    logic [7:0] pa = 8'h0;
    logic [31:0] pd = 32'h0, rd, prdata;
    logic err, pready, pslverr, conv, son, th, sqc, ers, avld, fail, fgd, eie;
    logic [3:0] ssel, lag = 4'h0;
    logic [1:0] rsel, sct, ejp;
    logic [23:0] trm;
    logic [11:0] ares, dac, gain;
    int failures = 0, n_compared = 0, nsq = 0, ner = 0;
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) nsq += sqc;
    always @(posedge clk) ner += ers;
    rcst_top #(.LONG_CYC(100), .SHORT_CYC(20)) rcst_top_inst (.i_mclk(clk), .i_rst(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_core_fail(fail),
        .i_short_run(srun), .i_adc_result(ares), .i_adc_valid(avld), .o_stim_sel(ssel),
        .o_stim_on(son), .o_track_hold(th), .o_adc_ref_sel(rsel), .o_adc_conv(conv),
        .o_adc_dac_code(dac), .o_forced_gain_disable(fgd), .o_error_irq_enable(eie),
        .o_sumsq_count_clear(sqc), .o_error_signal_reset(ers), .o_short_check_timing(sct),
        .o_error_judge_period(ejp), .o_angle_trim(trm), .o_gain_amp_sel(gain));
    rcst_front_model rcst_front_model_inst (.i_mclk(clk), .i_conv(conv), .i_code(dac),
        .i_ref(rsel), .i_adc_on(son && ssel == RCST_C_ADC), .i_fail_cmd(fcmd), .i_lag(lag),
        .o_result(ares), .o_valid(avld), .o_fail(fail));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, pa, pd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        apb(1'b0, a, 32'h0);
        for (int i = 0; i < 400 && rd[b] !== v; i++)
            apb(1'b0, a, 32'h0);
    endtask
    function automatic logic is_long(input logic [3:0] c);
        return c inside {RCST_C_ANG0, RCST_C_ANG45, RCST_C_ANG270, RCST_C_CONV};
    endfunction
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        test_done();
    end
    // long codes first, no reserved code
    logic [3:0] codes [12] = '{4'h5, 4'h6, 4'h7, 4'hc, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
    logic [11:0] c;
    initial begin
        void'($urandom(80739));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, RCST_OFF_LOOP, 32'h0);
        chk(rd, RCST_LOOP_RST);
        chk({fgd, gain}, {1'b1, RCST_LOOP_RST[11:0]});
        apb(1'b0, RCST_OFF_DIAG1, 32'h0);
        chk(rd, RCST_DIAG1_RST | 32'h100);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        // forced gain on, irq off, defaults kept
        apb(1'b1, RCST_OFF_LOOP, RCST_LOOP_RST & ~32'h3);
        apb(1'b1, RCST_OFF_TRIM, 32'h0);
        // timing 00, judge 10, counter clear
        apb(1'b1, RCST_OFF_DIAG1, 32'h18);
        srun <= 1'b0;
        poll(RCST_OFF_DIAG1, RCST_D1_SCRUN, 1'b0);
        chk({fgd, eie, sct, ejp, trm}, {2'b00, 2'b00, 2'b10, 24'h0});
        apb(1'b1, RCST_OFF_CTRL, 32'h10);
        apb(1'b0, RCST_OFF_STAT, 32'h0);
        chk(rd[RCST_ST_BUSY], 1'b0);
        foreach (codes[i]) begin
            apb(1'b1, RCST_OFF_CTRL, {22'h0, 2'($urandom), 4'h1, codes[i]});
            apb(1'b0, RCST_OFF_STAT, 32'h0);
            chk({rd[11:8], rd[4], rd[0]}, {codes[i], is_long(codes[i]), 1'b1});
            chk({ssel, son, th}, {codes[i], 1'b1, is_long(codes[i])});
            poll(RCST_OFF_STAT, RCST_ST_DONE, 1'b1);
            chk(rd[RCST_ST_PASS], 1'b1);
            apb(1'b1, RCST_OFF_CTRL, 32'h20);
            apb(1'b0, RCST_OFF_STAT, 32'h0);
            chk(rd[RCST_ST_DONE], 1'b0);
            $display("test code %h done", codes[i]);
        end
        fcmd <= 1'b1;
        apb(1'b1, RCST_OFF_CTRL, 32'h19);
        poll(RCST_OFF_STAT, RCST_ST_DONE, 1'b1);
        repeat (5) @(posedge clk);
        apb(1'b0, RCST_OFF_STAT, 32'h0);
        chk(rd[3:1], 3'b101);
        fcmd <= 1'b0;
        apb(1'b1, RCST_OFF_CTRL, 32'h20);
        apb(1'b1, RCST_OFF_DIAG1, 32'h30);
        apb(1'b0, RCST_OFF_STAT, 32'h0);
        chk(nsq, 32'd2);
        chk(ner, 32'd1);
        chk(rd[RCST_ST_ERR], 1'b0);
        $display("fault and clear test done");
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
            lag <= 4'($urandom);
            apb(1'b1, RCST_OFF_SWDAC, {20'h0, c});
            poll(RCST_OFF_SWRES, RCST_SW_VALID, 1'b1);
            chk(rd[11:0], c);
        end
        $display("software conversion test done");
        apb(1'b1, RCST_OFF_LOOP, RCST_LOOP_RST);
        repeat (2) @(posedge clk);
        chk(fgd, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
